// ===== design/hub_port_pkg.sv
// Purpose: Shared constants for the per-port hub status word block.
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses.
// Notes: Feature codes equal the status-word bit that each one controls.
package hub_port_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_REQUEST = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_HUBCTL = 8'h0c;

   // Status word bit positions.
   localparam int BIT_ATTACH = 0;
   localparam int BIT_ENABLE = 1;
   localparam int BIT_SUSPEND = 2;
   localparam int BIT_OCUR = 3;
   localparam int BIT_RESET = 4;
   localparam int BIT_POWER = 8;
   localparam int BIT_LOWSPD = 9;
   localparam int BIT_HIGHSPD = 10;
   localparam int BIT_TEST = 11;
   localparam int BIT_INDIC = 12;

   // Feature selectors carried in the request register.
   localparam logic [7:0] FEAT_ATTACH = 8'h00;
   localparam logic [7:0] FEAT_ENABLE = 8'h01;
   localparam logic [7:0] FEAT_SUSPEND = 8'h02;
   localparam logic [7:0] FEAT_OCUR = 8'h03;
   localparam logic [7:0] FEAT_RESET = 8'h04;
   localparam logic [7:0] FEAT_POWER = 8'h08;
   localparam logic [7:0] FEAT_LOWSPD = 8'h09;
   localparam logic [7:0] FEAT_HIGHSPD = 8'h0a;
   localparam logic [7:0] FEAT_TEST = 8'h0b;
   localparam logic [7:0] FEAT_INDIC = 8'h0c;

   // Request register fields.
   localparam int REQ_FEAT_LSB = 0;
   localparam int REQ_SET_BIT = 8;
   localparam int REQ_SEL_LSB = 12;
   localparam logic [3:0] SEL_DEFAULT = 4'h0;

   // Result and hub control register fields.
   localparam int RES_DONE_BIT = 0;
   localparam int RES_ERR_BIT = 1;
   localparam int HUB_LPC_BIT = 0;
   localparam int HUB_LPS_BIT = 1;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Values after hub reset.
   localparam logic POWER_RST = 1'b0;
   localparam logic [3:0] SEL_RST = 4'h0;
endpackage

// ===== design/hub_port_status.sv
// Purpose: Status bits of one hub downstream port, driven by the port state
//          machine and by set/clear feature requests written over AXI4-Lite.
// Assumes: Port state machine events arrive as one-cycle pulses on aclk.
// Notes: Summary of operation follows.
// Summary of operation
// - Powered port reports attached device presence.
// - Attach flag zero when unpowered or disconnected.
// - Attach set on disconnected-to-disabled with attach.
// - Attach feature requests change nothing.
// - Enable set only when reset completes.
// - Enable cleared by off, request, error, disconnect, reset.
// - Set-enable answered with request error.
// - Suspended port gets no forwarded downstream traffic.
// - Suspend set only when port enabled.
// - Suspend cleared by resume transitions or disable.
// - Overload follows this or affecting port over-current.
// - Overload, speed, clear-reset requests are no-ops.
// - Reset flag high exactly while resetting.
// - Power flag zero exactly when powered-off.
// - Set-power ignored when local power lost.
// - Power cleared by request or over-current.
// - Low-speed flag set for enabled low-speed device.
// - High-speed flag distinguishes high from full speed.
// - Test set only from disabled or suspended.
// - Indicator override follows selector or clear.
// - Overload gives amber unless overridden; set-power turns lamp off unless overloaded.
// - Reserved status bits read as zero.
module hub_port_status (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic dev_attached,
   input wire logic disc_to_disabled,
   input wire logic disconnect_det,
   input wire logic port_error,
   input wire logic reset_done,
   input wire logic eop_send_to_enabled,
   input wire logic restart_to_transmit,
   input wire logic oc_this_port,
   input wire logic oc_other_port,
   input wire logic oc_other_cut,
   input wire logic dev_low_speed,
   input wire logic dev_high_speed,
   output logic forward_en,
   output logic resume_req,
   output logic port_resetting,
   output logic port_powered,
   output logic test_mode,
   output logic [3:0] test_sel,
   output logic ind_override,
   output logic [3:0] ind_sel,
   output logic ind_amber,
   output logic ind_off
);

   typedef struct packed {
      logic attach;
      logic enable;
      logic suspend;
      logic ocur;
      logic resetting;
      logic power;
      logic lowspd;
      logic highspd;
      logic test;
      logic indic;
      logic [3:0] test_sel;
      logic [3:0] ind_sel;
      logic amber;
      logic lamp_off;
      logic fwd;
      logic resume;
      logic req_pend;
      logic req_set;
      logic [7:0] req_feat;
      logic [3:0] req_sel;
      logic res_done;
      logic res_err;
      logic hub_lpc;
      logic hub_lps;
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // Reserved positions stay zero because only named bits are placed.
   function automatic logic [31:0] status_word(input state_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[hub_port_pkg::BIT_ATTACH] = s.attach;
      w[hub_port_pkg::BIT_ENABLE] = s.enable;
      w[hub_port_pkg::BIT_SUSPEND] = s.suspend;
      w[hub_port_pkg::BIT_OCUR] = s.ocur;
      w[hub_port_pkg::BIT_RESET] = s.resetting;
      w[hub_port_pkg::BIT_POWER] = s.power;
      w[hub_port_pkg::BIT_LOWSPD] = s.lowspd;
      w[hub_port_pkg::BIT_HIGHSPD] = s.highspd;
      w[hub_port_pkg::BIT_TEST] = s.test;
      w[hub_port_pkg::BIT_INDIC] = s.indic;
      return w;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == hub_port_pkg::OFS_STATUS || a == hub_port_pkg::OFS_REQUEST
         || a == hub_port_pkg::OFS_RESULT || a == hub_port_pkg::OFS_HUBCTL;
   endfunction

   always_comb begin
      logic en_clr;
      logic pwr_off;
      logic set_req;
      logic do_write;
      logic test_ok;
      en_clr = 1'b0;
      pwr_off = 1'b0;
      set_req = st_r.req_pend & st_r.req_set;
      do_write = 1'b0;
      test_ok = 1'b0;
      st_nxt = st_r;
      st_nxt.resume = 1'b0;

      // Write address and data may arrive in either order.
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         do_write = 1'b1;
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = mapped(st_r.awaddr) ? hub_port_pkg::RESP_OKAY
                                            : hub_port_pkg::RESP_SLVERR;
      end

      // Request processing; a new request written now runs next cycle.
      if (st_r.req_pend) begin
         st_nxt.req_pend = 1'b0;
         st_nxt.res_done = 1'b1;
         st_nxt.res_err = 1'b0;
         case (st_r.req_feat)
            hub_port_pkg::FEAT_ATTACH: begin
               st_nxt.res_err = 1'b0;
            end
            hub_port_pkg::FEAT_ENABLE: begin
               if (st_r.req_set) begin
                  st_nxt.res_err = 1'b1;
               end else begin
                  en_clr = 1'b1;
               end
            end
            hub_port_pkg::FEAT_SUSPEND: begin
               if (st_r.req_set) begin
                  if (st_r.enable) begin
                     st_nxt.suspend = 1'b1;
                  end
               end else if (st_r.suspend) begin
                  // The flag falls when the resume sequence ends or the port is disabled.
                  st_nxt.resume = 1'b1;
               end
            end
            hub_port_pkg::FEAT_RESET: begin
               if (st_r.req_set && st_r.power && st_r.attach) begin
                  st_nxt.resetting = 1'b1;
                  en_clr = 1'b1;
               end
            end
            hub_port_pkg::FEAT_POWER: begin
               if (st_r.req_set) begin
                  if (!(st_r.hub_lpc && st_r.hub_lps)) begin
                     st_nxt.power = 1'b1;
                     st_nxt.lamp_off = 1'b1;
                  end
               end else begin
                  pwr_off = 1'b1;
               end
            end
            hub_port_pkg::FEAT_TEST: begin
               test_ok = st_r.power && (!st_r.enable || st_r.suspend);
               if (st_r.req_set && test_ok) begin
                  st_nxt.test = 1'b1;
                  st_nxt.test_sel = st_r.req_sel;
               end else if (st_r.req_set) begin
                  st_nxt.res_err = 1'b1;
               end
            end
            hub_port_pkg::FEAT_INDIC: begin
               if (st_r.req_set &&
                   st_r.req_sel != hub_port_pkg::SEL_DEFAULT) begin
                  st_nxt.indic = 1'b1;
                  st_nxt.ind_sel = st_r.req_sel;
               end else begin
                  st_nxt.indic = 1'b0;
                  st_nxt.ind_sel = hub_port_pkg::SEL_DEFAULT;
               end
            end
            hub_port_pkg::FEAT_OCUR, hub_port_pkg::FEAT_LOWSPD,
            hub_port_pkg::FEAT_HIGHSPD: begin
               st_nxt.res_err = 1'b0;
            end
            default: begin
               st_nxt.res_err = 1'b1;
            end
         endcase
      end

      if (do_write && st_r.awaddr == hub_port_pkg::OFS_REQUEST &&
          st_r.wstrb[0]) begin
         st_nxt.req_pend = 1'b1;
         st_nxt.res_done = 1'b0;
         st_nxt.req_feat = st_r.wdata[hub_port_pkg::REQ_FEAT_LSB +: 8];
         st_nxt.req_set = st_r.wdata[hub_port_pkg::REQ_SET_BIT];
         st_nxt.req_sel = st_r.wdata[hub_port_pkg::REQ_SEL_LSB +: 4];
      end
      if (do_write && st_r.awaddr == hub_port_pkg::OFS_HUBCTL &&
          st_r.wstrb[0]) begin
         st_nxt.hub_lpc = st_r.wdata[hub_port_pkg::HUB_LPC_BIT];
         st_nxt.hub_lps = st_r.wdata[hub_port_pkg::HUB_LPS_BIT];
      end

      // Port state machine events.
      if (reset_done && st_r.resetting) begin
         st_nxt.resetting = 1'b0;
         st_nxt.enable = 1'b1;
      end
      if (disc_to_disabled && st_r.power && dev_attached) begin
         st_nxt.attach = 1'b1;
      end
      if (disconnect_det) begin
         st_nxt.attach = 1'b0;
         en_clr = 1'b1;
      end
      if (port_error) begin
         en_clr = 1'b1;
      end
      if (eop_send_to_enabled || restart_to_transmit) begin
         st_nxt.suspend = 1'b0;
      end
      if (oc_this_port || oc_other_cut) begin
         pwr_off = 1'b1;
      end
      if (pwr_off) begin
         st_nxt.power = 1'b0;
         st_nxt.attach = 1'b0;
         st_nxt.resetting = 1'b0;
         st_nxt.lamp_off = 1'b0;
         en_clr = 1'b1;
      end
      if (en_clr) begin
         st_nxt.enable = 1'b0;
         st_nxt.suspend = 1'b0;
      end

      st_nxt.ocur = oc_this_port | oc_other_port;
      // Speed bits are only meaningful while the port is enabled.
      st_nxt.lowspd = st_nxt.enable & dev_low_speed;
      st_nxt.highspd = st_nxt.enable & !dev_low_speed
                       & dev_high_speed;
      st_nxt.fwd = st_nxt.enable & !st_nxt.suspend;
      if (st_nxt.ocur) begin
         st_nxt.lamp_off = 1'b0;
      end
      st_nxt.amber = st_nxt.ocur & !st_nxt.indic;

      // Read channel; reads see registered state only.
      if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = hub_port_pkg::RESP_OKAY;
         st_nxt.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            hub_port_pkg::OFS_STATUS: st_nxt.rdata = status_word(st_r);
            hub_port_pkg::OFS_REQUEST: begin
               st_nxt.rdata[hub_port_pkg::REQ_FEAT_LSB +: 8] = st_r.req_feat;
               st_nxt.rdata[hub_port_pkg::REQ_SET_BIT] = st_r.req_set;
               st_nxt.rdata[hub_port_pkg::REQ_SEL_LSB +: 4] = st_r.req_sel;
            end
            hub_port_pkg::OFS_RESULT: begin
               st_nxt.rdata[hub_port_pkg::RES_DONE_BIT] = st_r.res_done;
               st_nxt.rdata[hub_port_pkg::RES_ERR_BIT] = st_r.res_err;
            end
            hub_port_pkg::OFS_HUBCTL: begin
               st_nxt.rdata[hub_port_pkg::HUB_LPC_BIT] = st_r.hub_lpc;
               st_nxt.rdata[hub_port_pkg::HUB_LPS_BIT] = st_r.hub_lps;
            end
            default: st_nxt.rresp = hub_port_pkg::RESP_SLVERR;
         endcase
      end

      // Ready flags are registered so every output leaves a flip-flop.
      st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
      st_nxt.arready = !st_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.power <= hub_port_pkg::POWER_RST;
         st_r.test_sel <= hub_port_pkg::SEL_RST;
         st_r.ind_sel <= hub_port_pkg::SEL_RST;
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.arready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign forward_en = st_r.fwd;
   assign resume_req = st_r.resume;
   assign port_resetting = st_r.resetting;
   assign port_powered = st_r.power;
   assign test_mode = st_r.test;
   assign test_sel = st_r.test_sel;
   assign ind_override = st_r.indic;
   assign ind_sel = st_r.ind_sel;
   assign ind_amber = st_r.amber;
   assign ind_off = st_r.lamp_off;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic req_now;
   assign req_now = st_r.req_pend;

   attach_unpowered_a: assert property (
      !st_r.power |-> !st_r.attach)
      else $error("attach flag set while port unpowered");
   enable_on_reset_a: assert property (
      reset_done && st_r.resetting && !port_error && !disconnect_det
      && !oc_this_port && !oc_other_cut |=> st_r.enable && !st_r.resetting)
      else $error("port not enabled after reset completed");
   enable_clear_a: assert property (
      port_error || disconnect_det |=> !st_r.enable && !st_r.suspend)
      else $error("enable survived an error or disconnect");
   suspend_gate_a: assert property (
      req_now && st_r.req_set && st_r.req_feat == hub_port_pkg::FEAT_SUSPEND
      && !st_r.enable |=> !st_r.suspend)
      else $error("suspend set on a disabled port");
   overload_a: assert property (
      (oc_this_port || oc_other_port) |=> st_r.ocur ##1 (st_r.ocur ||
      !$past(oc_this_port || oc_other_port)))
      else $error("overload flag does not follow over-current");
   reset_powered_a: assert property (
      !st_r.power |-> !st_r.resetting && !port_resetting)
      else $error("reset flag high while unpowered");
   power_noop_a: assert property (
      req_now && st_r.req_set && st_r.req_feat == hub_port_pkg::FEAT_POWER
      && st_r.hub_lpc && st_r.hub_lps && !st_r.power |=> !st_r.power)
      else $error("set-power acted with local power lost");
   test_refuse_a: assert property (
      req_now && st_r.req_set && st_r.req_feat == hub_port_pkg::FEAT_TEST
      && st_r.enable && !st_r.suspend && !st_r.test
      |=> st_r.res_err && !st_r.test)
      else $error("test mode accepted from an active port");
   indic_clear_a: assert property (
      req_now && !st_r.req_set && st_r.req_feat == hub_port_pkg::FEAT_INDIC
      |=> !st_r.indic ##1 !ind_amber || st_r.ocur)
      else $error("indicator override not cleared");
   speed_gate_a: assert property (
      st_r.lowspd || st_r.highspd |-> st_r.enable
      && !(st_r.lowspd && st_r.highspd))
      else $error("speed flags set on a disabled port");

   reset_seq_c: cover property (st_r.resetting ##[1:20] st_r.enable);
   suspend_c: cover property (st_r.enable ##[1:20] st_r.suspend);
   test_c: cover property (req_now ##1 st_r.test);
   amber_c: cover property (st_r.ocur ##1 ind_amber);

endmodule // hub_port_status

// ===== dv/host_model.sv
// Purpose: AXI4-Lite master standing in for host software on the hub.
// Assumes: One write and one read at most are under way at a time.
// Notes: Waits have no limit of their own; the bench watchdog ends a hang.
module host_model (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic [2:0] s_axi_awprot,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic [2:0] s_axi_arprot,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
      {s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
   end

   // Address and data go out together; each drops at the edge taking it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule // host_model

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the hub port status block.
// Assumes: Requests act one cycle after the write answer; port pulses last
//          one cycle.
// Notes: Speed bits are compared only while the port is enabled.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, test_sel, ind_sel;
   logic [1:0] s_axi_bresp, s_axi_rresp, hub;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic dev_attached, dev_low_speed, dev_high_speed;
   logic oc_this_port, oc_other_port;
   logic forward_en, resume_req, port_resetting, port_powered, test_mode;
   logic ind_override, ind_amber, ind_off;
   logic [6:0] ev = 7'h00;
   wire logic disc_to_disabled, disconnect_det, port_error, reset_done;
   wire logic eop_send_to_enabled, restart_to_transmit, oc_other_cut;
   logic [31:0] st;
   logic [7:0] nf [4];
   bit off;
   bit rsm;
   int err_count, checks, seed;

   assign {oc_other_cut, restart_to_transmit, eop_send_to_enabled,
           reset_done, port_error, disconnect_det, disc_to_disabled} = ev;

   hub_port_status dut (.*);
   host_model host (.*);

   always #50 aclk = ~aclk;

   task automatic chk(input string n, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   function automatic void pwr_off();
      st = st & 32'h0000_1808;
      off = 1'b0;
   endfunction

   // Reference model of one request; returns the expected error flag.
   function automatic bit model(bit s, logic [7:0] f, logic [3:0] sel);
      rsm = 1'b0;
      case (f)
         hub_port_pkg::FEAT_ATTACH, hub_port_pkg::FEAT_OCUR,
         hub_port_pkg::FEAT_LOWSPD, hub_port_pkg::FEAT_HIGHSPD: ;
         hub_port_pkg::FEAT_ENABLE: if (s) return 1'b1;
            else st[2:1] = 2'b00;
         hub_port_pkg::FEAT_SUSPEND: if (s && st[1]) st[2] = 1'b1;
            else if (!s) rsm = st[2];
         hub_port_pkg::FEAT_RESET: if (s && st[8] && st[0]) begin
            st[4] = 1'b1;
            st[2:1] = 2'b00;
         end
         hub_port_pkg::FEAT_POWER: if (!s) pwr_off();
            else if (hub != 2'b11 && !oc_this_port) begin
               st[8] = 1'b1;
               off = 1'b1;
            end
         hub_port_pkg::FEAT_TEST: if (s) begin
            if (st[8] && (!st[1] || st[2])) st[11] = 1'b1;
            else return 1'b1;
         end
         hub_port_pkg::FEAT_INDIC:
            st[12] = s && sel != hub_port_pkg::SEL_DEFAULT;
         default: return 1'b1;
      endcase
      return 1'b0;
   endfunction

   task automatic cmp();
      logic [31:0] d, m;
      logic [1:0] r;
      m = st[1] ? 32'hffff_ffff : 32'hffff_f9ff;
      host.rd(hub_port_pkg::OFS_STATUS, d, r);
      chk("status", d & m, st & m);
      chk("rresp", r, hub_port_pkg::RESP_OKAY);
      chk("outs", {forward_en, port_resetting, port_powered, test_mode,
         ind_override, ind_amber, ind_off}, {st[1] & ~st[2], st[4], st[8],
         st[11], st[12], st[3] & ~st[12], off});
   endtask

   task automatic req(input bit s, input logic [7:0] f, input logic [3:0] sel);
      logic [31:0] d;
      logic [1:0] r;
      bit e;
      e = model(s, f, sel);
      host.wr(hub_port_pkg::OFS_REQUEST, {16'h0000, sel, 3'h0, s, f}, r);
      chk("bresp", r, hub_port_pkg::RESP_OKAY);
      // The resume pulse stands for one cycle only, so look mid-cycle.
      @(negedge aclk);
      chk("resume_req", resume_req, rsm);
      repeat (2) @(posedge aclk);
      host.rd(hub_port_pkg::OFS_RESULT, d, r);
      chk("result", d[1:0], {e, 1'b1});
      cmp();
   endtask

   task automatic pulse(input int i);
      @(posedge aclk);
      ev[i] <= 1'b1;
      @(posedge aclk);
      ev <= 7'h00;
      @(posedge aclk);
   endtask

   task automatic results();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] sel;
      seed = 54483;
      st = 32'h0;
      hub = 2'b00;
      {dev_attached, dev_low_speed, dev_high_speed} = 3'h0;
      {oc_this_port, oc_other_port} = 2'h0;
      nf = '{hub_port_pkg::FEAT_ATTACH, hub_port_pkg::FEAT_OCUR,
             hub_port_pkg::FEAT_LOWSPD, hub_port_pkg::FEAT_HIGHSPD};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      cmp();
      host.rd(8'h10, d, r);
      chk("rresp", r, hub_port_pkg::RESP_SLVERR);
      host.wr(8'h20, 32'hffff_ffff, r);
      chk("bresp", r, hub_port_pkg::RESP_SLVERR);
      req(1, hub_port_pkg::FEAT_POWER, 0);
      dev_attached <= 1'b1;
      pulse(0);
      st[0] = 1'b1;
      cmp();
      foreach (nf[i]) begin
         req(1, nf[i], 0);
         req(0, nf[i], 0);
      end
      req(0, hub_port_pkg::FEAT_RESET, 0);
      req(1, hub_port_pkg::FEAT_ENABLE, 0);
      req(1, 8'h05, 0);
      req(1, hub_port_pkg::FEAT_SUSPEND, 0);
      req(1, hub_port_pkg::FEAT_RESET, 0);
      dev_high_speed <= 1'b1;
      pulse(3);
      st[4] = 1'b0;
      st[1] = 1'b1;
      st[10:9] = 2'b10;
      cmp();
      req(1, hub_port_pkg::FEAT_TEST, 0);
      // The port error comes last because it leaves the port disabled.
      for (int i = 5; i > 1; i--) begin
         if (i == 3) continue;
         req(1, hub_port_pkg::FEAT_SUSPEND, 0);
         req(0, hub_port_pkg::FEAT_SUSPEND, 0);
         pulse(i);
         st[2] = 1'b0;
         if (i == 2) st[1] = 1'b0;
         cmp();
      end
      dev_high_speed <= 1'b0;
      dev_low_speed <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) req(1, hub_port_pkg::FEAT_SUSPEND, 0);
         req(1, hub_port_pkg::FEAT_RESET, 0);
         pulse(3);
         st[4] = 1'b0;
         st[1] = 1'b1;
         st[10:9] = 2'b01;
         cmp();
         if (k == 0) req(0, hub_port_pkg::FEAT_ENABLE, 0);
      end
      dev_attached <= 1'b0;
      pulse(1);
      st[1:0] = 2'b00;
      cmp();
      dev_attached <= 1'b1;
      pulse(0);
      st[0] = 1'b1;
      cmp();
      oc_other_port <= 1'b1;
      @(posedge aclk);
      st[3] = 1'b1;
      off = 1'b0;
      cmp();
      oc_other_port <= 1'b0;
      @(posedge aclk);
      st[3] = 1'b0;
      cmp();
      oc_this_port <= 1'b1;
      @(posedge aclk);
      pwr_off();
      st[3] = 1'b1;
      cmp();
      req(1, hub_port_pkg::FEAT_POWER, 0);
      oc_this_port <= 1'b0;
      // Let the level settle before the model reads it.
      @(posedge aclk);
      st[3] = 1'b0;
      req(1, hub_port_pkg::FEAT_POWER, 0);
      pulse(6);
      pwr_off();
      cmp();
      host.wr(hub_port_pkg::OFS_HUBCTL, 32'h0000_0003, r);
      hub = 2'b11;
      req(1, hub_port_pkg::FEAT_POWER, 0);
      host.wr(hub_port_pkg::OFS_HUBCTL, 32'h0000_0001, r);
      hub = 2'b01;
      req(1, hub_port_pkg::FEAT_POWER, 0);
      repeat (3) begin
         sel = 4'({$random(seed)} % 15 + 1);
         req(1, hub_port_pkg::FEAT_INDIC, sel);
         chk("ind_sel", ind_sel, sel);
         req(0, hub_port_pkg::FEAT_INDIC, 0);
      end
      req(1, hub_port_pkg::FEAT_INDIC, 4'h5);
      req(1, hub_port_pkg::FEAT_INDIC, hub_port_pkg::SEL_DEFAULT);
      pulse(0);
      st[0] = 1'b1;
      req(1, hub_port_pkg::FEAT_RESET, 0);
      pulse(3);
      st[4] = 1'b0;
      st[1] = 1'b1;
      st[10:9] = 2'b01;
      req(1, hub_port_pkg::FEAT_SUSPEND, 0);
      req(1, hub_port_pkg::FEAT_TEST, 4'h6);
      chk("test_sel", test_sel, 4'h6);
      req(0, hub_port_pkg::FEAT_TEST, 0);
      results();
   end

   // The whole sequence needs about six hundred cycles.
   initial begin
      repeat (8000) @(posedge aclk);
      err_count++;
      results();
   end
endmodule // tb_top
